/* core/embedded_block_ram.sv */
// embedded block ram: two ports, width matching, write modes, apb config
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - 9216 bit store, registered inputs and outputs
// - single, true dual or pseudo dual port
// - shapes 8192x1 to 256x36; true dual stops x18
// - each port picks its own width
// - contiguous bit map, word 0 lsb first
// - contents preloadable at configuration
// - preload plus write disable gives rom
// - address and data registered on clock edge
// - output register per port, usable or bypassed
// - normal mode: writes leave output unchanged
// - write through: written data shown on output
// - read first: old word shown, x9+ only
// - port reset clears own output asynchronously
// - active low global reset clears both outputs
// - global reset always acts asynchronously
module embedded_block_ram
    import block_ram_pkg::*;
#(
    parameter logic [MEM_BITS-1:0] INIT = '0
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CE_A,
    input  wire logic        WE_A,
    input  wire logic [12:0] ADDR_A,
    input  wire logic [35:0] DIN_A,
    output logic      [35:0] DOUT_A,
    input  wire logic        PORT_A_OUTPUT_RESET,
    input  wire logic        CE_B,
    input  wire logic        WE_B,
    input  wire logic [12:0] ADDR_B,
    input  wire logic [35:0] DIN_B,
    output logic      [35:0] DOUT_B,
    input  wire logic        PORT_B_OUTPUT_RESET,
    input  wire logic        GLOBAL_RESET_N
);
    typedef struct packed {
        logic        valid;
        logic        we;
        logic [5:0]  off;
        width_t      width;
        wr_mode_t    mode;
        logic [35:0] din;
    } cap_t;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [31:0]      wcount;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        cap_t             cap_a;
        cap_t             cap_b;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic logic [5:0] width_bits(input width_t w);
        case (w)
            W1:      return 6'h01;
            W2:      return 6'h02;
            W4:      return 6'h04;
            W9:      return 6'h09;
            W18:     return 6'h12;
            default: return 6'h24;
        endcase
    endfunction

    // shift trick: 1<<36 wraps to zero, so minus one gives all ones
    function automatic logic [35:0] width_ones(input width_t w);
        return (36'h1 << width_bits(w)) - 36'h1;
    endfunction

    // first bit of the word in the shared array
    function automatic logic [13:0] bit_addr(input logic [12:0] a, input width_t w);
        case (w)
            W1:      return {1'b0, a};
            W2:      return {a[11:0], 1'b0};
            W4:      return {a[10:0], 2'b00};
            W9:      return 14'(a[9:0]) * 14'd9;
            W18:     return 14'(a[8:0]) * 14'd18;
            default: return 14'(a[7:0]) * ROW_BITS_14;
        endcase
    endfunction

    function automatic width_t legal_width(input logic [2:0] raw, input logic dual);
        width_t w;
        w = (raw > 3'(W36)) ? W1 : width_t'(raw);
        if (dual && w == W36) begin
            w = W18;
        end
        return w;
    endfunction

    function automatic wr_mode_t legal_mode(input logic [1:0] raw, input width_t w);
        wr_mode_t m;
        m = (raw > 2'(WR_READ_FIRST)) ? WR_NORMAL : wr_mode_t'(raw);
        // read-first only exists for the widths with parity bits
        if (m == WR_READ_FIRST && w < W9) begin
            m = WR_NORMAL;
        end
        return m;
    endfunction

    mem_mode_t   mode;
    logic        cfg_legal;
    width_t      width_a;
    width_t      width_b;
    wr_mode_t    wmode_a;
    wr_mode_t    wmode_b;
    logic        oreg_a;
    logic        oreg_b;
    logic        rom;
    logic        en_a;
    logic        en_b;
    logic        we_a;
    logic        we_b;
    logic        read_a;
    logic [13:0] ba_a;
    logic [13:0] ba_b;
    logic [7:0]  row_a;
    logic [7:0]  row_b;
    logic [5:0]  off_a;
    logic [5:0]  off_b;
    logic [35:0] wmask_a;
    logic [35:0] wmask_b;
    logic [35:0] q_a;
    logic [35:0] q_b;
    logic [35:0] word_a;
    logic [35:0] word_b;
    logic        load_a;
    logic        load_b;
    logic        sel_setup;
    logic        access;
    logic        mapped;
    logic [31:0] rd_mux;

    // configuration decode, illegal codes folded onto safe shapes
    always_comb begin
        mode = (s.cfg[CFG_MODE_LSB +: 2] == 2'h3) ? MODE_SINGLE
                                                  : mem_mode_t'(s.cfg[CFG_MODE_LSB +: 2]);
        width_a   = legal_width(s.cfg[CFG_WA_LSB +: 3], mode == MODE_TRUE_DUAL);
        width_b   = legal_width(s.cfg[CFG_WB_LSB +: 3], mode == MODE_TRUE_DUAL);
        wmode_a   = legal_mode(s.cfg[CFG_MA_LSB +: 2], width_a);
        wmode_b   = legal_mode(s.cfg[CFG_MB_LSB +: 2], width_b);
        oreg_a    = s.cfg[CFG_OREGA_BIT];
        oreg_b    = s.cfg[CFG_OREGB_BIT];
        rom       = s.cfg[CFG_ROM_BIT];
        cfg_legal = (s.cfg[CFG_MODE_LSB +: 2] != 2'h3)
                    && (3'(width_a) == s.cfg[CFG_WA_LSB +: 3])
                    && (3'(width_b) == s.cfg[CFG_WB_LSB +: 3]);
    end

    // port gating by memory shape and by clock enable
    always_comb begin
        en_a   = CE_A;
        en_b   = CE_B && (mode != MODE_SINGLE);
        we_a   = en_a && WE_A && !rom;
        we_b   = en_b && WE_B && !rom && (mode == MODE_TRUE_DUAL);
        read_a = mode != MODE_PSEUDO_DUAL;
        ba_a   = bit_addr(ADDR_A, width_a);
        ba_b   = bit_addr(ADDR_B, width_b);
        row_a  = 8'(ba_a / ROW_BITS_14);
        row_b  = 8'(ba_b / ROW_BITS_14);
        off_a  = 6'(ba_a % ROW_BITS_14);
        off_b  = 6'(ba_b % ROW_BITS_14);
        wmask_a = we_a ? (width_ones(width_a) << off_a) : 36'h0;
        wmask_b = we_b ? (width_ones(width_b) << off_b) : 36'h0;
    end

    // array registers address and data at the enabled edge
    bit_array #(
        .INIT    (INIT)
    ) u_array (
        .clk     (CLK),
        .en_a    (en_a),
        .row_a   (row_a),
        .wmask_a (wmask_a),
        .wdata_a (DIN_A << off_a),
        .q_a     (q_a),
        .en_b    (en_b),
        .row_b   (row_b),
        .wmask_b (wmask_b),
        .wdata_b (DIN_B << off_b),
        .q_b     (q_b)
    );

    // word for the output stage, chosen by the write mode
    always_comb begin
        word_a = (s.cap_a.we && s.cap_a.mode == WR_THROUGH)
                 ? (s.cap_a.din & width_ones(s.cap_a.width))
                 : ((q_a >> s.cap_a.off) & width_ones(s.cap_a.width));
        word_b = (s.cap_b.we && s.cap_b.mode == WR_THROUGH)
                 ? (s.cap_b.din & width_ones(s.cap_b.width))
                 : ((q_b >> s.cap_b.off) & width_ones(s.cap_b.width));
        load_a = s.cap_a.valid && !(s.cap_a.we && s.cap_a.mode == WR_NORMAL);
        load_b = s.cap_b.valid && !(s.cap_b.we && s.cap_b.mode == WR_NORMAL);
    end

    // apb decode, zero wait states
    always_comb begin
        sel_setup = PSEL && !PENABLE;
        access    = PSEL && PENABLE && s.pready;
        mapped    = (PADDR == OFF_CONFIG) || (PADDR == OFF_STATUS) || (PADDR == OFF_WCOUNT);
        case (PADDR)
            OFF_CONFIG: rd_mux = 32'(s.cfg);
            OFF_STATUS: rd_mux = 32'({width_b, width_a, cfg_legal});
            OFF_WCOUNT: rd_mux = s.wcount;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s         = s;
        next_s.pready  = sel_setup;
        next_s.pslverr = sel_setup && !mapped;
        if (sel_setup && !PWRITE) begin
            next_s.prdata = rd_mux;
        end
        if (access && PWRITE && PADDR == OFF_CONFIG) begin
            next_s.cfg = PWDATA[CFG_W-1:0];
        end
        // a write in the clearing cycle is still counted
        if (access && PWRITE && PADDR == OFF_WCOUNT) begin
            next_s.wcount = 32'(we_a) + 32'(we_b);
        end else begin
            next_s.wcount = s.wcount + 32'(we_a) + 32'(we_b);
        end
        next_s.cap_a.valid = en_a && read_a;
        next_s.cap_b.valid = en_b;
        if (en_a) begin
            next_s.cap_a.we    = we_a;
            next_s.cap_a.off   = off_a;
            next_s.cap_a.width = width_a;
            next_s.cap_a.mode  = wmode_a;
            next_s.cap_a.din   = DIN_A;
        end
        if (en_b) begin
            next_s.cap_b.we    = we_b;
            next_s.cap_b.off   = off_b;
            next_s.cap_b.width = width_b;
            next_s.cap_b.mode  = wmode_b;
            next_s.cap_b.din   = DIN_B;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s        <= '0;
            s.cfg    <= CFG_RESET;
            s.wcount <= WCOUNT_RESET;
        end else begin
            s <= next_s;
        end
    end

    port_output_stage u_out_a (
        .clk            (CLK),
        .rst            (RST),
        .local_reset    (PORT_A_OUTPUT_RESET),
        .global_reset_n (GLOBAL_RESET_N),
        .ce             (CE_A),
        .load           (load_a),
        .oreg_en        (oreg_a),
        .word           (word_a),
        .dout           (DOUT_A)
    );

    port_output_stage u_out_b (
        .clk            (CLK),
        .rst            (RST),
        .local_reset    (PORT_B_OUTPUT_RESET),
        .global_reset_n (GLOBAL_RESET_N),
        .ce             (CE_B),
        .load           (load_b),
        .oreg_en        (oreg_b),
        .word           (word_b),
        .dout           (DOUT_B)
    );

    assign PRDATA  = s.prdata;
    assign PREADY  = s.pready;
    assign PSLVERR = s.pslverr;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST || !GLOBAL_RESET_N || PORT_A_OUTPUT_RESET);

    sequence read_then_hold_ce;
        load_a && oreg_a ##1 CE_A && oreg_a;
    endsequence

    a_bypass_latency: assert property (
        load_a && !oreg_a |=> DOUT_A == $past(word_a))
        else $error("bypassed read data late or wrong");

    a_oreg_latency: assert property (
        read_then_hold_ce |=> DOUT_A == $past(word_a, 2))
        else $error("registered read data not two clocks after capture");

    a_normal_hold: assert property (
        s.cap_a.valid && s.cap_a.we && s.cap_a.mode == WR_NORMAL && !oreg_a |=> $stable(DOUT_A))
        else $error("normal write changed port a output");

    a_through_copy: assert property (
        en_a && we_a && read_a && wmode_a == WR_THROUGH && !oreg_a
        |=> ##1 DOUT_A == ($past(DIN_A, 2) & width_ones(width_a)))
        else $error("write through did not show written data");

    a_read_first_width: assert property (
        s.cap_a.mode == WR_READ_FIRST |-> s.cap_a.width >= W9)
        else $error("read first used on narrow width");

    a_ce_hold: assert property (
        !CE_A ##1 !CE_A |=> $stable(DOUT_A))
        else $error("port a output moved without enable");

    a_rom_no_write: assert property (
        rom |-> wmask_a == 36'h0 && wmask_b == 36'h0)
        else $error("write reached array in rom use");

    a_dual_width: assert property (
        mode == MODE_TRUE_DUAL |-> width_a != W36 && width_b != W36)
        else $error("36 bit width in true dual port");

    a_port_reset: assert property (disable iff (RST)
        PORT_A_OUTPUT_RESET |-> DOUT_A == 36'h0)
        else $error("port a reset did not clear output");

    a_global_reset: assert property (disable iff (RST)
        !GLOBAL_RESET_N |-> DOUT_A == 36'h0 && DOUT_B == 36'h0)
        else $error("global reset did not clear outputs");

    a_apb_ready: assert property (
        PSEL && !PENABLE |=> PREADY ##1 !PREADY || (PSEL && !PENABLE))
        else $error("apb ready not one cycle after setup");
endmodule

/* core/ebr_pkg.sv */
// constants and types shared by the embedded block ram design
package block_ram_pkg;
    localparam int          MEM_BITS      = 9216;
    localparam int          ROW_BITS      = 36;
    localparam int          ROWS          = 256;
    localparam int          ADDR_W        = 13;
    localparam int          DATA_W        = 36;
    localparam int          BADDR_W       = 14;
    localparam logic [13:0] ROW_BITS_14   = 14'h0024;
    localparam logic [7:0]  OFF_CONFIG    = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_WCOUNT    = 8'h08;
    localparam int          CFG_W         = 15;
    localparam int          CFG_MODE_LSB  = 0;
    localparam int          CFG_WA_LSB    = 2;
    localparam int          CFG_WB_LSB    = 5;
    localparam int          CFG_MA_LSB    = 8;
    localparam int          CFG_MB_LSB    = 10;
    localparam int          CFG_OREGA_BIT = 12;
    localparam int          CFG_OREGB_BIT = 13;
    localparam int          CFG_ROM_BIT   = 14;
    localparam logic [14:0] CFG_RESET     = 15'h00b4;
    localparam int          ST_LEGAL_BIT  = 0;
    localparam int          ST_WA_LSB     = 1;
    localparam int          ST_WB_LSB     = 4;
    localparam logic [31:0] WCOUNT_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL} mem_mode_t;
    typedef enum logic [2:0] {W1, W2, W4, W9, W18, W36} width_t;
    typedef enum logic [1:0] {WR_NORMAL, WR_THROUGH, WR_READ_FIRST} wr_mode_t;
endpackage

/* core/bit_array.sv */
// 9216-bit storage array, 256 rows of 36 bits, two bit-masked ports
`timescale 1ns/1ps
module bit_array
    import block_ram_pkg::*;
#(
    parameter logic [MEM_BITS-1:0] INIT = '0
) (
    input  wire logic        clk,
    input  wire logic        en_a,
    input  wire logic [7:0]  row_a,
    input  wire logic [35:0] wmask_a,
    input  wire logic [35:0] wdata_a,
    output logic      [35:0] q_a,
    input  wire logic        en_b,
    input  wire logic [7:0]  row_b,
    input  wire logic [35:0] wmask_b,
    input  wire logic [35:0] wdata_b,
    output logic      [35:0] q_b
);
    logic [35:0] mem [ROWS];

    // contents loaded at configuration time
    initial begin
        for (int r = 0; r < ROWS; r++) begin
            mem[r] = INIT[r*ROW_BITS +: ROW_BITS];
        end
    end

    // reads take the row before this edge's write: old data for read-first
    always @(posedge clk) begin
        for (int i = 0; i < ROW_BITS; i++) begin
            if (wmask_b[i]) begin
                mem[row_b][i] <= wdata_b[i];
            end
            if (wmask_a[i]) begin
                mem[row_a][i] <= wdata_a[i];
            end
        end
        if (en_a) begin
            q_a <= mem[row_a];
        end
        if (en_b) begin
            q_b <= mem[row_b];
        end
    end
endmodule

/* core/port_output_stage.sv */
// per-port output latch with optional output register and async clears
`timescale 1ns/1ps
module port_output_stage (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        local_reset,
    input  wire logic        global_reset_n,
    input  wire logic        ce,
    input  wire logic        load,
    input  wire logic        oreg_en,
    input  wire logic [35:0] word,
    output logic      [35:0] dout
);
    typedef struct packed {
        logic [35:0] lat;
        logic [35:0] q;
    } stage_t;

    stage_t s;
    stage_t next_s;

    always_comb begin
        next_s = s;
        if (load) begin
            next_s.lat = word;
        end
        if (!oreg_en) begin
            next_s.q = next_s.lat;
        end else if (ce) begin
            next_s.q = s.lat;
        end
    end

    always_ff @(posedge clk or posedge local_reset or negedge global_reset_n) begin
        if (local_reset || !global_reset_n) begin
            s <= '0;
        end else if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.q;
endmodule

/* verif/fabric_port.sv */
// behavioural fabric logic driving one memory port
`timescale 1ns/1ps
module fabric_port (
    input  wire logic        clk,
    output logic             ce,
    output logic             we,
    output logic      [12:0] addr,
    output logic      [35:0] din
);
    initial begin
        ce   = 1'b0;
        we   = 1'b0;
        addr = '0;
        din  = '0;
    end
    // one request held for n edges
    task automatic go(input logic c, input logic w, input logic [12:0] a, input logic [35:0] d, input int n);
        @(posedge clk);
        ce   <= c;
        we   <= w;
        addr <= a;
        din  <= d;
        repeat (n) @(posedge clk);
        // enables drop at once so any later reset finds them low
        ce   <= 1'b0;
        we   <= 1'b0;
        // released lines never keep the last value
        addr <= ~a;
        din  <= ~d;
        // output of the last capture only stands after the following edge
        @(posedge clk);
        #1;
    endtask
endmodule

/* verif/tb_embedded_block_ram.sv */
// self-checking bench for the embedded block ram
`timescale 1ns/1ps
module tb_embedded_block_ram
    import block_ram_pkg::*;
;
    localparam logic [35:0] INIT_W = 36'h987654321;
    localparam logic [35:0] V1     = 36'h1_1223_3445;
    localparam logic [35:0] V2     = 36'h5_5667_7889;
    localparam logic [35:0] V3     = 36'ha_abbc_cdde;
    localparam logic [35:0] DA     = 36'h0_0002_a0b5;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = '0;
    logic [31:0] pwdata  = '0;
    logic        rst_a   = 1'b0;
    logic        rst_b   = 1'b0;
    logic        gr_n    = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ce_a;
    logic        we_a;
    logic [12:0] addr_a;
    logic [35:0] din_a;
    logic [35:0] dout_a;
    logic        ce_b;
    logic        we_b;
    logic [12:0] addr_b;
    logic [35:0] din_b;
    logic [35:0] dout_b;
    logic [31:0] q;
    logic        e;
    int          miscompares = 0;
    int          compares    = 0;

    always #2 clk = ~clk;

    embedded_block_ram #(.INIT(MEM_BITS'(INIT_W))) dut_u (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CE_A(ce_a), .WE_A(we_a), .ADDR_A(addr_a), .DIN_A(din_a), .DOUT_A(dout_a),
        .PORT_A_OUTPUT_RESET(rst_a), .CE_B(ce_b), .WE_B(we_b), .ADDR_B(addr_b), .DIN_B(din_b),
        .DOUT_B(dout_b), .PORT_B_OUTPUT_RESET(rst_b), .GLOBAL_RESET_N(gr_n)
    );
    fabric_port pa (.clk(clk), .ce(ce_a), .we(we_a), .addr(addr_a), .din(din_a));
    fabric_port pb (.clk(clk), .ce(ce_b), .we(we_b), .addr(addr_b), .din(din_b));

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
        apb(1'b0, a, 32'h0);
        check({4'h0, q}, {4'h0, exp});
        check({35'h0, e}, {35'h0, exp_e});
    endtask

    function automatic logic [31:0] cfg(input int md, input int wa, input int wb, input int ma, input int oa,
                                        input int rom);
        return 32'((md << CFG_MODE_LSB) | (wa << CFG_WA_LSB) | (wb << CFG_WB_LSB) | (ma << CFG_MA_LSB)
            | (oa << CFG_OREGA_BIT) | (rom << CFG_ROM_BIT));
    endfunction

    function automatic logic [31:0] stat(input int leg, input int wa, input int wb);
        return 32'((leg << ST_LEGAL_BIT) | (wa << ST_WA_LSB) | (wb << ST_WB_LSB));
    endfunction

    task automatic t_regs();
        rd_chk(OFF_CONFIG, {17'h0, CFG_RESET}, 1'b0);
        rd_chk(OFF_STATUS, stat(1, 5, 5), 1'b0);
        rd_chk(OFF_WCOUNT, WCOUNT_RESET, 1'b0);
        rd_chk(8'h0c, 32'h0, 1'b1);
    endtask

    task automatic t_rom();
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 0, 0, 1));
        pa.go(1'b1, 1'b1, 13'h0, V1, 1);
        pa.go(1'b1, 1'b0, 13'h0, '0, 1);
        check(dout_a, INIT_W);
        rd_chk(OFF_WCOUNT, 32'h0, 1'b0);
    endtask

    task automatic t_modes();
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 0, 0, 0));
        pa.go(1'b1, 1'b1, 13'h5, V1, 1);
        check(dout_a, INIT_W);
        pa.go(1'b1, 1'b0, 13'h5, '0, 1);
        check(dout_a, V1);
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 1, 0, 0));
        pa.go(1'b1, 1'b1, 13'h5, V2, 1);
        check(dout_a, V2);
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 2, 0, 0));
        pa.go(1'b1, 1'b1, 13'h5, V3, 1);
        check(dout_a, V2);
        pa.go(1'b1, 1'b0, 13'h5, '0, 1);
        check(dout_a, V3);
        // narrow ports fall back to normal behaviour
        apb(1'b1, OFF_CONFIG, cfg(0, 2, 5, 2, 0, 0));
        pa.go(1'b1, 1'b1, 13'h0, 36'ha, 1);
        check(dout_a, V3);
        rd_chk(OFF_WCOUNT, 32'h4, 1'b0);
        apb(1'b1, OFF_WCOUNT, 32'h0);
        rd_chk(OFF_WCOUNT, 32'h0, 1'b0);
    endtask

    task automatic t_oreg();
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 0, 1, 0));
        // the output register needs the enable again two edges after capture
        pa.go(1'b1, 1'b0, 13'h0, '0, 3);
        check(dout_a, {INIT_W[35:4], 4'ha});
        @(posedge clk);
        rst_a <= 1'b1;
        #1;
        check(dout_a, 36'h0);
        @(posedge clk);
        rst_a <= 1'b0;
        fork
            pa.go(1'b1, 1'b0, 13'h5, '0, 3);
            begin
                repeat (3) @(posedge clk);
                #1;
                check(dout_a, 36'h0);
                @(posedge clk);
                #1;
                check(dout_a, V3);
            end
        join
    endtask

    task automatic t_hold();
        apb(1'b1, OFF_CONFIG, cfg(0, 5, 5, 0, 0, 0));
        pa.go(1'b0, 1'b1, 13'h6, V1, 1);
        check(dout_a, V3);
        pa.go(1'b1, 1'b0, 13'h6, '0, 1);
        check(dout_a, 36'h0);
    endtask

    task automatic t_dual();
        apb(1'b1, OFF_CONFIG, cfg(1, 4, 3, 0, 0, 0));
        rd_chk(OFF_STATUS, stat(1, 4, 3), 1'b0);
        pa.go(1'b1, 1'b1, 13'h0, DA, 1);
        pb.go(1'b1, 1'b0, 13'h0, '0, 1);
        check(dout_b, {27'h0, DA[8:0]});
        pb.go(1'b1, 1'b0, 13'h1, '0, 1);
        check(dout_b, {27'h0, DA[17:9]});
        pb.go(1'b1, 1'b1, 13'h2, 36'h1cd, 1);
        pa.go(1'b1, 1'b0, 13'h1, '0, 1);
        check(dout_a, {18'h0, INIT_W[35:27], 9'h1cd});
        @(posedge clk);
        rst_a <= 1'b1;
        #1;
        check(dout_a, 36'h0);
        check(dout_b, {27'h0, DA[17:9]});
        @(posedge clk);
        rst_a <= 1'b0;
        gr_n  <= 1'b0;
        #1;
        check(dout_b, 36'h0);
        @(posedge clk);
        gr_n <= 1'b1;
        apb(1'b1, OFF_CONFIG, cfg(1, 4, 3, 0, 0, 0) | (32'h1 << CFG_MB_LSB));
        pb.go(1'b1, 1'b1, 13'h3, 36'h0f0, 1);
        check(dout_b, 36'h0f0);
        // a 36-bit port is not offered with two read-write ports
        apb(1'b1, OFF_CONFIG, cfg(1, 5, 3, 0, 0, 0));
        rd_chk(OFF_STATUS, stat(0, 4, 3), 1'b0);
        apb(1'b1, OFF_CONFIG, cfg(2, 4, 3, 0, 0, 0));
        pb.go(1'b1, 1'b1, 13'h0, 36'h1ff, 1);
        pb.go(1'b1, 1'b0, 13'h0, '0, 1);
        check(dout_b, {27'h0, DA[8:0]});
    endtask

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_rom();
        t_modes();
        t_oreg();
        t_hold();
        t_dual();
        test_done();
    end

    // whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule
